// File: design/backup_rail_slot_defs.vh
// constants for the backup rail strobe slot register
`ifndef BACKUP_RAIL_SLOT_DEFS_VH
`define BACKUP_RAIL_SLOT_DEFS_VH
`define SLOT_REG_OFFSET 8'h24
`define SLOT_REG_RESET 8'h12
`define SLOT_REG_MASK 8'h33
`define SLOT_B_HI 5
`define SLOT_B_LO 4
`define SLOT_A_HI 1
`define SLOT_A_LO 0
`define SLOT_CODE_NONE0 2'h0
`define SLOT_CODE_STROBE1 2'h1
`define SLOT_CODE_STROBE2 2'h2
`define SLOT_CODE_NONE3 2'h3
`define STROBE_ONE 4'h1
`define STROBE_TWO 4'h2
`define SLOT_A_RESET 2'h2
`define SLOT_B_RESET 2'h1
`define SLOT_REG_ZERO 8'h00
`define RST_SYNC_INIT 1'h0
`define RST_SYNC_DONE 1'h1
`define SEAL_SYNC_INIT 1'h1
`define RAIL_ON 1'h1
`define RAIL_OFF 1'h0
`endif

// File: design/backup_rail_strobe_slots.v
// backup rail strobe slot register and early strobe enable logic
`timescale 1ns/1ps
`include "backup_rail_slot_defs.vh"

module backup_rail_strobe_slots (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // register port
    input wire [7:0] regAddr,
    input wire regWrite,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    // sequencer side
    input wire [3:0] strobeNum,
    input wire strobeValid,
    input wire seqPowerDown,
    input wire freshness_seal_flag,
    // rail enables
    output reg backup_rail_a,
    output reg backup_rail_b
);
    wire resetSync_n;
    wire sealSync;
    wire sealBroken;
    wire regSelect;
    wire regHit;
    wire strobeAllowed;
    wire powerDownAllowed;
    wire [1:0] backup_rail_a_slot;
    wire [1:0] backup_rail_b_slot;
    wire aSet;
    wire aClear;
    wire bSet;
    wire bClear;
    reg [7:0] next_regRdata;
    reg next_backup_rail_a;
    reg next_backup_rail_b;

    // reset release
    sync_two_flop #(
        .RESET_LEVEL(`RST_SYNC_INIT)
    ) u_reset_sync (
        .clk(clk),
        .clear_n(reset_n),
        .dataIn(`RST_SYNC_DONE),
        .dataOut(resetSync_n)
    );

    // seal flag synchroniser, reads as broken until a real sample has landed
    sync_two_flop #(
        .RESET_LEVEL(`SEAL_SYNC_INIT)
    ) u_seal_sync (
        .clk(clk),
        .clear_n(resetSync_n),
        .dataIn(freshness_seal_flag),
        .dataOut(sealSync)
    );

    assign sealBroken = sealSync;
    assign regSelect = (regAddr == `SLOT_REG_OFFSET);
    assign regHit = regWrite && regSelect;
    assign strobeAllowed = strobeValid && !sealBroken;
    assign powerDownAllowed = seqPowerDown && !sealBroken;

    // slot field of rail a
    rail_slot_unit #(
        .RESET_CODE(`SLOT_A_RESET)
    ) u_slot_a (
        .clk(clk),
        .clear_n(resetSync_n),
        .writeHit(regHit),
        .writeCode(regWdata[`SLOT_A_HI:`SLOT_A_LO]),
        .strobeNum(strobeNum),
        .strobeAllowed(strobeAllowed),
        .powerDownAllowed(powerDownAllowed),
        .slotCode(backup_rail_a_slot),
        .railSet(aSet),
        .railClear(aClear)
    );

    // slot field of rail b
    rail_slot_unit #(
        .RESET_CODE(`SLOT_B_RESET)
    ) u_slot_b (
        .clk(clk),
        .clear_n(resetSync_n),
        .writeHit(regHit),
        .writeCode(regWdata[`SLOT_B_HI:`SLOT_B_LO]),
        .strobeNum(strobeNum),
        .strobeAllowed(strobeAllowed),
        .powerDownAllowed(powerDownAllowed),
        .slotCode(backup_rail_b_slot),
        .railSet(bSet),
        .railClear(bClear)
    );

    // rail enables, a set in the same cycle wins over a power-down
    always @*
    begin
        next_backup_rail_a = backup_rail_a;
        next_backup_rail_b = backup_rail_b;
        if (aSet)
        begin
            next_backup_rail_a = `RAIL_ON;
        end
        else if (aClear)
        begin
            next_backup_rail_a = `RAIL_OFF;
        end
        if (bSet)
        begin
            next_backup_rail_b = `RAIL_ON;
        end
        else if (bClear)
        begin
            next_backup_rail_b = `RAIL_OFF;
        end
    end

    always @(posedge clk or negedge resetSync_n)
    begin
        if (!resetSync_n)
        begin
            backup_rail_a <= `RAIL_OFF;
            backup_rail_b <= `RAIL_OFF;
        end
        else
        begin
            backup_rail_a <= next_backup_rail_a;
            backup_rail_b <= next_backup_rail_b;
        end
    end

    // read image, reserved bits stay zero
    always @*
    begin
        next_regRdata = `SLOT_REG_ZERO;
        if (regSelect)
        begin
            next_regRdata[`SLOT_B_HI:`SLOT_B_LO] = backup_rail_b_slot;
            next_regRdata[`SLOT_A_HI:`SLOT_A_LO] = backup_rail_a_slot;
        end
    end

    always @(posedge clk or negedge resetSync_n)
    begin
        if (!resetSync_n)
        begin
            regRdata <= `SLOT_REG_ZERO;
        end
        else
        begin
            regRdata <= next_regRdata;
        end
    end
endmodule // backup_rail_strobe_slots

// two-flop synchroniser with an asynchronous clear to a chosen level
module sync_two_flop #(
    parameter [0:0] RESET_LEVEL = `RST_SYNC_INIT
) (
    // clock and clear
    input wire clk,
    input wire clear_n,
    // data
    input wire dataIn,
    output reg dataOut
);
    reg dataMeta;

    // only the second flop is read outside
    always @(posedge clk or negedge clear_n)
    begin
        if (!clear_n)
        begin
            dataMeta <= RESET_LEVEL;
            dataOut <= RESET_LEVEL;
        end
        else
        begin
            dataMeta <= dataIn;
            dataOut <= dataMeta;
        end
    end
endmodule // sync_two_flop

// one rail's slot field with its strobe and power-down decode
module rail_slot_unit #(
    parameter [1:0] RESET_CODE = `SLOT_CODE_NONE0
) (
    // clock and clear
    input wire clk,
    input wire clear_n,
    // register write
    input wire writeHit,
    input wire [1:0] writeCode,
    // sequencer side
    input wire [3:0] strobeNum,
    input wire strobeAllowed,
    input wire powerDownAllowed,
    // slot state and rail requests
    output reg [1:0] slotCode,
    output wire railSet,
    output wire railClear
);
    wire atStrobeOne;
    wire atStrobeTwo;
    wire underControl;

    always @(posedge clk or negedge clear_n)
    begin
        if (!clear_n)
        begin
            slotCode <= RESET_CODE;
        end
        else if (writeHit)
        begin
            slotCode <= writeCode;
        end
    end

    assign atStrobeOne = (slotCode == `SLOT_CODE_STROBE1) && (strobeNum == `STROBE_ONE);
    assign atStrobeTwo = (slotCode == `SLOT_CODE_STROBE2) && (strobeNum == `STROBE_TWO);
    // codes 0 and 3 keep the rail away from the sequencer both ways
    assign underControl = (slotCode != `SLOT_CODE_NONE0) && (slotCode != `SLOT_CODE_NONE3);
    assign railSet = strobeAllowed && (atStrobeOne || atStrobeTwo);
    assign railClear = powerDownAllowed && underControl;
endmodule // rail_slot_unit

// File: testbench/backup_rail_strobe_slots_tb.sv
// self-checking bench for the backup rail slot register
`timescale 1ns/1ps
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t in slot bench", $time); end end
module backup_rail_strobe_slots_tb;
    reg clk = 0, reset_n = 0, regWrite = 0, strobeValid = 0, seqPowerDown = 0;
    reg freshness_seal_flag = 0;
    reg [7:0] regAddr = 8'h24, regWdata = 8'h00;
    reg [3:0] strobeNum = 4'h0;
    wire [7:0] regRdata;
    wire backup_rail_a, backup_rail_b;
    integer n_fail = 0, checks_done = 0;
    backup_rail_strobe_slots u_dut (
        .clk(clk),
        .reset_n(reset_n),
        .regAddr(regAddr),
        .regWrite(regWrite),
        .regWdata(regWdata),
        .regRdata(regRdata),
        .strobeNum(strobeNum),
        .strobeValid(strobeValid),
        .seqPowerDown(seqPowerDown),
        .freshness_seal_flag(freshness_seal_flag),
        .backup_rail_a(backup_rail_a),
        .backup_rail_b(backup_rail_b)
    );
    initial forever #12.5 clk = ~clk;
    task wr(input [7:0] a, input [7:0] d);
        {regAddr, regWdata, regWrite} = {a, d, 1'b1};
        @(negedge clk) {regAddr, regWrite} = {8'h24, 1'b0};
        repeat (2) @(negedge clk);
    endtask
    task go(input [3:0] n, input p, input [1:0] e);
        {strobeValid, strobeNum, seqPowerDown} = {!p, n, p};
        @(negedge clk) {strobeValid, seqPowerDown} = 2'h0;
        `CK({backup_rail_b, backup_rail_a}, e)
        @(negedge clk);
    endtask
    task rst(input s);
        {reset_n, freshness_seal_flag} = {1'b0, s};
        repeat (10) @(negedge clk);
        reset_n = 1;
        repeat (5) @(negedge clk);
    endtask
    task complete_run;
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        rst(0);
        `CK(regRdata, 8'h12)
        wr(8'h24, 8'hff);
        `CK(regRdata, 8'h33)
        go(4'h1, 0, 2'h0);
        go(4'h2, 0, 2'h0);
        wr(8'h24, 8'h00);
        `CK(regRdata, 8'h00)
        go(4'h1, 0, 2'h0);
        go(4'h2, 0, 2'h0);
        wr(8'h24, 8'h12);
        go(4'h1, 0, 2'h2);
        go(4'h2, 0, 2'h3);
        wr(8'hff, 8'h00);
        `CK(regRdata, 8'h12)
        wr(8'h24, 8'hff);
        `CK(regRdata, 8'h33)
        go(4'h0, 1, 2'h3);
        wr(8'h24, 8'h00);
        go(4'h0, 1, 2'h3);
        wr(8'h24, 8'h21);
        `CK(regRdata, 8'h21)
        go(4'h0, 1, 2'h0);
        go(4'h1, 0, 2'h1);
        go(4'h2, 0, 2'h3);
        freshness_seal_flag = 1;
        repeat (3) @(negedge clk);
        go(4'h0, 1, 2'h3);
        rst(1);
        `CK(regRdata, 8'h12)
        go(4'h1, 0, 2'h0);
        go(4'h2, 0, 2'h0);
        complete_run;
    end
endmodule // backup_rail_strobe_slots_tb

// File: testbench/brs_chk.sv
// assertions on the backup rail slot register ports
`timescale 1ns/1ps
module brs_chk (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // register port
    input wire [7:0] regAddr,
    input wire regWrite,
    input wire [7:0] regRdata,
    // sequencer side
    input wire [3:0] strobeNum,
    input wire strobeValid,
    input wire seqPowerDown,
    input wire freshness_seal_flag,
    // rail enables
    input wire backup_rail_a,
    input wire backup_rail_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_RSV: assert property (regRdata[7:6] == 2'h0 && regRdata[3:2] == 2'h0)
        else $error("reserved bits set");
    AST_A: assert property ($past(reset_n, 4) && strobeValid && strobeNum == 4'h2 &&
        regAddr == 8'h24 && regRdata[1:0] == 2'h2 && !$past(regWrite) &&
        !$past(freshness_seal_flag, 2) |=> backup_rail_a) else $error("rail a not enabled");
    AST_B: assert property ($past(reset_n, 4) && strobeValid && strobeNum == 4'h1 &&
        regAddr == 8'h24 && regRdata[5:4] == 2'h1 && !$past(regWrite) &&
        !$past(freshness_seal_flag, 2) |=> backup_rail_b) else $error("rail b not enabled");
    AST_SEAL: assert property ($rose(backup_rail_a) || $rose(backup_rail_b)
        |-> !$past(freshness_seal_flag, 3)) else $error("strobe ran while sealed");
    AST_KEEP: assert property (freshness_seal_flag [*3]
        |=> !$fell(backup_rail_a) && !$fell(backup_rail_b)) else $error("rail off after seal");
    cover property (strobeValid && freshness_seal_flag);
    cover property ($rose(backup_rail_a));
    cover property (regWrite && regAddr == 8'h24);
    cover property (seqPowerDown && freshness_seal_flag);
endmodule // brs_chk
bind backup_rail_strobe_slots brs_chk u_chk (
    .clk(clk),
    .reset_n(reset_n),
    .regAddr(regAddr),
    .regWrite(regWrite),
    .regRdata(regRdata),
    .strobeNum(strobeNum),
    .strobeValid(strobeValid),
    .seqPowerDown(seqPowerDown),
    .freshness_seal_flag(freshness_seal_flag),
    .backup_rail_a(backup_rail_a),
    .backup_rail_b(backup_rail_b)
);
